// >>> rtl/asx_alu.sv
// combinational arithmetic core: subtract, swap and exclusive or
module asx_alu (
  input  wire asx_pkg::asx_op_t op,
  input  wire logic [7:0]       acc,
  input  wire logic [7:0]       lit,
  input  wire logic [7:0]       freg,
  input  wire logic             c_in,
  output asx_pkg::asx_alu_t     o_alu
);
  import asx_pkg::*;

  wire logic       is_lit_sub = (op == ASX_OP_LIT_SUB);
  wire logic       is_sub     = is_lit_sub || (op == ASX_OP_REG_SUB) ||
                                (op == ASX_OP_REG_SUBB);
  wire logic       is_xor     = (op == ASX_OP_XOR_LIT) ||
                                (op == ASX_OP_XOR_REG);
  wire logic [7:0] opnd       = is_lit_sub ? lit : freg;
  // borrow is the inverted carry, only for the borrow form
  wire logic       brw        = (op == ASX_OP_REG_SUBB) ? ~c_in : 1'b0;
  // two's complement: a + ~w + ~borrow, carry out means no borrow
  wire logic [8:0] sum        = {1'b0, opnd} + {1'b0, ~acc} +
                                {8'h00, ~brw};
  wire logic [4:0] nsum       = {1'b0, opnd[3:0]} + {1'b0, ~acc[3:0]} +
                                {4'h0, ~brw};
  wire logic [7:0] swp        = {freg[3:0], freg[7:4]};
  wire logic [7:0] xsrc       = (op == ASX_OP_XOR_LIT) ? lit : freg;
  wire logic [7:0] xr         = acc ^ xsrc;
  wire logic [7:0] res        = is_sub ? sum[7:0] :
                                is_xor ? xr :
                                (op == ASX_OP_SWAP) ? swp : acc;

  assign o_alu.res    = res;
  assign o_alu.c      = sum[8];
  assign o_alu.dc     = nsum[4];
  assign o_alu.z      = (res == 8'h00);
  assign o_alu.c_upd  = is_sub;
  assign o_alu.dc_upd = is_sub;
  assign o_alu.z_upd  = is_sub || is_xor;

endmodule : asx_alu

// >>> rtl/asx_core.sv
// execution unit for subtract, swap, xor, direction load and sleep
// ==========================================================================
//
// Decided for this implementation: the address map and register access over AXI4-Lite.
module asx_core (
  input  wire logic                i_clk_sys,
  input  wire logic                i_rst_n,

  // instruction from the decoder
  input  wire logic                i_instr_valid,
  input  wire asx_pkg::asx_instr_t i_instr,

  // file register space
  input  wire logic [7:0]          i_freg_rdata,
  output logic [6:0]               o_freg_raddr,
  output asx_pkg::asx_fwr_t        o_freg_wr,

  // watchdog, oscillator and port direction control
  output logic                     o_wdt_clear,
  output logic                     o_osc_run,
  input  wire logic                i_wake,
  output logic [7:0]               o_port_a_direction,
  output logic [7:0]               o_port_b_direction,

  // axi4-lite slave
  input  wire logic [7:0]          s_axi_awaddr,
  input  wire logic                s_axi_awvalid,
  output logic                     s_axi_awready,
  input  wire logic [31:0]         s_axi_wdata,
  input  wire logic [3:0]          s_axi_wstrb,
  input  wire logic                s_axi_wvalid,
  output logic                     s_axi_wready,
  output logic [1:0]               s_axi_bresp,
  output logic                     s_axi_bvalid,
  input  wire logic                s_axi_bready,

  input  wire logic [7:0]          s_axi_araddr,
  input  wire logic                s_axi_arvalid,
  output logic                     s_axi_arready,
  output logic [31:0]              s_axi_rdata,
  output logic [1:0]               s_axi_rresp,
  output logic                     s_axi_rvalid,
  input  wire logic                s_axi_rready
);
  import asx_pkg::*;

  // ========================================================================
  // state
  // ========================================================================
  typedef enum logic [0:0] {ASX_RUN, ASX_SLEEP} asx_state_t;

  // execution state and accumulator
  asx_state_t state_reg, state_next;
  logic [7:0] acc_reg, acc_next;

  // arithmetic flags
  logic       c_reg, c_next;
  logic       dc_reg, dc_next;
  logic       z_reg, z_next;

  // power status, both active low and set out of reset
  logic       pd_n_reg, pd_n_next;
  logic       to_n_reg, to_n_next;

  // direction registers for operands 5, 6 and 7
  logic [7:0] dir_reg [3];
  logic [7:0] dir_next [3];

  // registered requests towards the register space and the watchdog
  asx_fwr_t   fwr_reg, fwr_next;
  logic       wdt_clr_reg;

  // wake pin synchroniser, only the second stage is read
  logic       wake_s1_reg, wake_s2_reg;

  // ========================================================================
  // axi4-lite write side
  // ========================================================================
  logic        aw_hold_reg, w_hold_reg;
  logic [7:0]  awaddr_reg;
  logic [31:0] wdata_reg;
  logic [3:0]  wstrb_reg;
  logic        bvalid_reg;
  logic [1:0]  bresp_reg;

  wire logic aw_take  = s_axi_awvalid && s_axi_awready;
  wire logic w_take   = s_axi_wvalid && s_axi_wready;
  wire logic aw_have  = aw_hold_reg || aw_take;
  wire logic w_have   = w_hold_reg || w_take;
  wire logic wr_fire  = aw_have && w_have && !bvalid_reg;

  // a held half wins over the live bus once it has been taken
  wire logic [7:0]  wa = aw_hold_reg ? awaddr_reg : s_axi_awaddr;
  wire logic [31:0] wd = w_hold_reg ? wdata_reg : s_axi_wdata;
  wire logic [3:0]  ws = w_hold_reg ? wstrb_reg : s_axi_wstrb;

  // a partial instruction word would run a half-built opcode, so refuse it
  wire logic wr_instr = wr_fire && (wa == ASX_OFS_INSTR) && (&ws[2:0]);
  wire logic wr_acc   = wr_fire && (wa == ASX_OFS_ACC) && ws[0];
  wire logic wr_wake  = wr_fire && (wa == ASX_OFS_WAKE) && ws[0] && wd[0];
  // only the writable offsets answer okay
  wire logic wr_ok    = (wa == ASX_OFS_INSTR) || (wa == ASX_OFS_ACC) ||
                        (wa == ASX_OFS_WAKE);

  // one write at a time: nothing new is taken until the response is gone
  assign s_axi_awready = !aw_hold_reg && !bvalid_reg;
  assign s_axi_wready  = !w_hold_reg && !bvalid_reg;
  assign s_axi_bvalid  = bvalid_reg;
  assign s_axi_bresp   = bresp_reg;

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      aw_hold_reg <= 1'b0;
      w_hold_reg  <= 1'b0;
      awaddr_reg  <= 8'h00;
      wdata_reg   <= 32'h0000_0000;
      wstrb_reg   <= 4'h0;
      bvalid_reg  <= 1'b0;
      bresp_reg   <= ASX_RESP_OKAY;
    end else begin
      if (aw_take) awaddr_reg <= s_axi_awaddr;
      if (w_take) wdata_reg <= s_axi_wdata;
      if (w_take) wstrb_reg <= s_axi_wstrb;
      // a half that arrives first waits here for its partner
      aw_hold_reg <= aw_have && !wr_fire;
      w_hold_reg  <= w_have && !wr_fire;
      if (wr_fire) begin
        bvalid_reg <= 1'b1;
        bresp_reg  <= wr_ok ? ASX_RESP_OKAY : ASX_RESP_SLVERR;
      end else if (s_axi_bready) begin
        bvalid_reg <= 1'b0;
      end
    end
  end

  // ========================================================================
  // axi4-lite read side
  // ========================================================================
  logic        rvalid_reg;
  logic [31:0] rdata_reg;
  logic [1:0]  rresp_reg;
  logic [31:0] rd_mux;
  logic        rd_ok;

  // one read at a time: the next address waits until the data is taken
  assign s_axi_arready = !rvalid_reg;
  assign s_axi_rvalid  = rvalid_reg;
  assign s_axi_rdata   = rdata_reg;
  assign s_axi_rresp   = rresp_reg;

  always_comb begin
    rd_ok  = 1'b1;
    rd_mux = 32'h0000_0000;
    case (s_axi_araddr)
      ASX_OFS_ACC:    rd_mux[7:0] = acc_reg;
      ASX_OFS_STATUS: begin
        rd_mux[ASX_ST_C]     = c_reg;
        rd_mux[ASX_ST_DC]    = dc_reg;
        rd_mux[ASX_ST_Z]     = z_reg;
        rd_mux[ASX_ST_PD_N]  = pd_n_reg;
        rd_mux[ASX_ST_TO_N]  = to_n_reg;
        rd_mux[ASX_ST_SLEEP] = (state_reg == ASX_SLEEP);
      end
      ASX_OFS_DIR_A:  rd_mux[7:0] = dir_reg[0];
      ASX_OFS_DIR_B:  rd_mux[7:0] = dir_reg[1];
      ASX_OFS_DIR_C:  rd_mux[7:0] = dir_reg[2];
      // write-only registers read back as zero
      ASX_OFS_INSTR,
      ASX_OFS_WAKE:   rd_mux = 32'h0000_0000;
      // unmapped offsets answer with an error
      default:        rd_ok = 1'b0;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      rvalid_reg <= 1'b0;
      rdata_reg  <= 32'h0000_0000;
      rresp_reg  <= ASX_RESP_OKAY;
    end else if (s_axi_arvalid && !rvalid_reg) begin
      // data is frozen at the edge that takes the address
      rvalid_reg <= 1'b1;
      rdata_reg  <= rd_mux;
      rresp_reg  <= rd_ok ? ASX_RESP_OKAY : ASX_RESP_SLVERR;
    end else if (s_axi_rready) begin
      rvalid_reg <= 1'b0;
    end
  end

  // ========================================================================
  // instruction select: decoder port, or a software-issued word
  // ========================================================================
  asx_instr_t sw_instr;
  assign sw_instr.lit  = wd[ASX_INS_LIT_LSB +: 8];
  assign sw_instr.addr = wd[ASX_INS_ADDR_LSB +: 7];
  assign sw_instr.dest = wd[ASX_INS_DEST_BIT];
  assign sw_instr.op   = asx_op_t'(wd[ASX_INS_OP_LSB +: 4]);

  // the decoder port wins when both present an instruction
  wire logic       running = (state_reg == ASX_RUN);
  wire logic       ex_vld  = running && (i_instr_valid || wr_instr);
  wire asx_instr_t ex      = i_instr_valid ? i_instr : sw_instr;

  // register read is combinational so the op ends in one cycle
  assign o_freg_raddr = ex.addr;

  asx_alu_t alu;

  // an idle cycle feeds the alu a no-op so no flag can move
  asx_alu u_alu (
    .op    (ex_vld ? ex.op : ASX_OP_NONE),
    .acc   (acc_reg),
    .lit   (ex.lit),
    .freg  (i_freg_rdata),
    .c_in  (c_reg),
    .o_alu (alu)
  );

  // ========================================================================
  // execute
  // ========================================================================
  wire logic reg_form = (ex.op == ASX_OP_REG_SUB) ||
                        (ex.op == ASX_OP_REG_SUBB) ||
                        (ex.op == ASX_OP_SWAP) ||
                        (ex.op == ASX_OP_XOR_REG);
  wire logic lit_form = (ex.op == ASX_OP_LIT_SUB) ||
                        (ex.op == ASX_OP_XOR_LIT);

  // literal forms have no destination bit and always write the accumulator
  wire logic to_acc   = ex_vld && (lit_form || (reg_form && !ex.dest));
  wire logic to_reg   = ex_vld && reg_form && ex.dest;

  // control instructions with side effects only
  wire logic do_sleep = ex_vld && (ex.op == ASX_OP_SLEEP);
  wire logic do_dir   = ex_vld && (ex.op == ASX_OP_DIR_LOAD);

  // a bus wake request counts the same as the synchronised pin
  wire logic wake_now = wake_s2_reg || wr_wake;

  always_comb begin
    state_next  = state_reg;
    acc_next    = wr_acc ? wd[7:0] : acc_reg;
    c_next      = c_reg;
    dc_next     = dc_reg;
    z_next      = z_reg;
    pd_n_next   = pd_n_reg;
    to_n_next   = to_n_reg;
    dir_next    = dir_reg;
    fwr_next.we   = to_reg;
    fwr_next.addr = ex.addr;
    fwr_next.data = alu.res;

    if (to_acc) acc_next = alu.res;
    // flags follow the alu's update mask, so a swap keeps every flag
    if (alu.c_upd) c_next = alu.c;
    if (alu.dc_upd) dc_next = alu.dc;
    if (alu.z_upd) z_next = alu.z;
    // operands other than 5 to 7 are ignored
    if (do_dir) begin
      case (ex.addr[2:0])
        ASX_DIR_SEL_A: dir_next[0] = acc_reg;
        ASX_DIR_SEL_B: dir_next[1] = acc_reg;
        ASX_DIR_SEL_C: dir_next[2] = acc_reg;
        default:       dir_next    = dir_reg;
      endcase
      if (ex.addr[6:3] != 4'h0) dir_next = dir_reg;
    end

    // sleep stops execution from the next edge; only a wake leaves it
    case (state_reg)
      ASX_RUN: begin
        if (do_sleep) begin
          pd_n_next  = 1'b0;
          to_n_next  = 1'b1;
          state_next = ASX_SLEEP;
        end
      end
      ASX_SLEEP: begin
        if (wake_now) state_next = ASX_RUN;
      end
      default: state_next = ASX_RUN;
    endcase
  end

  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      state_reg   <= ASX_RUN;
      acc_reg     <= ASX_ACC_RST;
      c_reg       <= 1'b0;
      dc_reg      <= 1'b0;
      z_reg       <= 1'b0;
      pd_n_reg    <= 1'b1;
      to_n_reg    <= 1'b1;
      dir_reg     <= '{ASX_DIR_RST, ASX_DIR_RST, ASX_DIR_RST};
      // no write request and no watchdog pulse out of reset
      fwr_reg     <= '0;
      wdt_clr_reg <= 1'b0;
      wake_s1_reg <= 1'b0;
      wake_s2_reg <= 1'b0;
    end else begin
      state_reg   <= state_next;
      acc_reg     <= acc_next;
      c_reg       <= c_next;
      dc_reg      <= dc_next;
      z_reg       <= z_next;
      pd_n_reg    <= pd_n_next;
      to_n_reg    <= to_n_next;
      dir_reg     <= dir_next;
      // write request and watchdog pulse each stand for one cycle
      fwr_reg     <= fwr_next;
      wdt_clr_reg <= do_sleep;
      // two stages before the asynchronous wake pin is read
      wake_s1_reg <= i_wake;
      wake_s2_reg <= wake_s1_reg;
    end
  end

  // ========================================================================
  // outputs
  // ========================================================================
  // one pulse clears counter to zero and the prescaler together
  assign o_wdt_clear        = wdt_clr_reg;
  // low while asleep; the clock source outside stops on it
  assign o_osc_run          = running;
  assign o_freg_wr          = fwr_reg;
  // the third direction register has no pin and is seen over the bus only
  assign o_port_a_direction = dir_reg[0];
  assign o_port_b_direction = dir_reg[1];

endmodule : asx_core

// >>> rtl/asx_pkg.sv
// package: opcodes, register map, field layouts and reset values for asx
package asx_pkg;

  typedef enum logic [3:0] {
    ASX_OP_NONE,
    ASX_OP_LIT_SUB,
    ASX_OP_REG_SUB,
    ASX_OP_REG_SUBB,
    ASX_OP_SWAP,
    ASX_OP_XOR_LIT,
    ASX_OP_XOR_REG,
    ASX_OP_DIR_LOAD,
    ASX_OP_SLEEP
  } asx_op_t;

  // instruction as handed over by the decoder
  typedef struct packed {
    asx_op_t    op;
    logic [6:0] addr;
    logic       dest;
    logic [7:0] lit;
  } asx_instr_t;

  // file register write request towards the register space
  typedef struct packed {
    logic       we;
    logic [6:0] addr;
    logic [7:0] data;
  } asx_fwr_t;

  // alu result and flag outcome
  typedef struct packed {
    logic [7:0] res;
    logic       c;
    logic       dc;
    logic       z;
    logic       c_upd;
    logic       dc_upd;
    logic       z_upd;
  } asx_alu_t;

  localparam logic [2:0] ASX_DIR_SEL_A = 3'h5;
  localparam logic [2:0] ASX_DIR_SEL_B = 3'h6;
  localparam logic [2:0] ASX_DIR_SEL_C = 3'h7;

  localparam logic [7:0] ASX_ACC_RST   = 8'h00;
  localparam logic [7:0] ASX_DIR_RST   = 8'hFF;
  localparam logic [7:0] ASX_WDT_CLR   = 8'h00;

  // axi4-lite register byte offsets
  localparam logic [7:0] ASX_OFS_INSTR  = 8'h00;
  localparam logic [7:0] ASX_OFS_ACC    = 8'h04;
  localparam logic [7:0] ASX_OFS_STATUS = 8'h08;
  localparam logic [7:0] ASX_OFS_DIR_A  = 8'h0C;
  localparam logic [7:0] ASX_OFS_DIR_B  = 8'h10;
  localparam logic [7:0] ASX_OFS_DIR_C  = 8'h14;
  localparam logic [7:0] ASX_OFS_WAKE   = 8'h18;

  // instruction register fields
  localparam int ASX_INS_LIT_LSB  = 0;
  localparam int ASX_INS_ADDR_LSB = 8;
  localparam int ASX_INS_DEST_BIT = 15;
  localparam int ASX_INS_OP_LSB   = 16;

  // status register fields
  localparam int ASX_ST_C     = 0;
  localparam int ASX_ST_DC    = 1;
  localparam int ASX_ST_Z     = 2;
  localparam int ASX_ST_PD_N  = 3;
  localparam int ASX_ST_TO_N  = 4;
  localparam int ASX_ST_SLEEP = 5;

  localparam logic [1:0] ASX_RESP_OKAY   = 2'b00;
  localparam logic [1:0] ASX_RESP_SLVERR = 2'b10;

endpackage : asx_pkg

// >>> tb/asx_freg_model.sv
// partner model: file register space with same-cycle read
module asx_freg_model (
  input  wire logic                i_clk_sys,
  input  wire logic [6:0]          i_raddr,
  input  wire asx_pkg::asx_fwr_t   i_wr,
  output logic [7:0]               o_rdata
);
  timeunit 1ns;
  timeprecision 1ps;
  import asx_pkg::*;
  // full 0 to 127 address space
  logic [7:0] mem [128];
  initial begin
    for (int i = 0; i < 128; i++) begin
      mem[i] = 8'(i * 37 + 11);
    end
  end
  assign o_rdata = mem[i_raddr];
  always @(posedge i_clk_sys) begin
    if (i_wr.we) begin
      mem[i_wr.addr] <= i_wr.data;
    end
  end
endmodule : asx_freg_model

// >>> tb/asx_monitor.sv
// checker: port-level relations of the subtract, swap, xor and sleep unit
module asx_monitor (
  input wire logic                i_clk_sys,
  input wire logic                i_rst_n,
  input wire logic                i_instr_valid,
  input wire asx_pkg::asx_instr_t i_instr,
  input wire logic [7:0]          i_freg_rdata,
  input wire logic [6:0]          o_freg_raddr,
  input wire asx_pkg::asx_fwr_t   o_freg_wr,
  input wire logic                o_wdt_clear,
  input wire logic                o_osc_run,
  input wire logic [7:0]          o_port_a_direction
);
  timeunit 1ns;
  timeprecision 1ps;
  import asx_pkg::*;
  // ==========================================================================
  // helpers
  logic go;
  logic regop;
  logic litop;
  // an instruction only counts while the core runs
  assign go    = i_instr_valid && o_osc_run;
  assign regop = i_instr.op inside {ASX_OP_REG_SUB, ASX_OP_REG_SUBB,
                                    ASX_OP_SWAP, ASX_OP_XOR_REG};
  assign litop = i_instr.op inside {ASX_OP_LIT_SUB, ASX_OP_XOR_LIT,
                                    ASX_OP_DIR_LOAD, ASX_OP_SLEEP};
  default clocking cb @(posedge i_clk_sys);
  endclocking
  default disable iff (!i_rst_n);
  // ==========================================================================
  // properties
  sequence s_sleep;
    go && i_instr.op == ASX_OP_SLEEP;
  endsequence
  sequence s_pulse;
    o_wdt_clear ##1 !o_wdt_clear;
  endsequence
  property p_wdt_pulse;
    s_sleep |=> s_pulse;
  endproperty
  property p_osc_stop;
    s_sleep |-> ##[1:2] !o_osc_run;
  endproperty
  property p_refuse;
    i_instr_valid && !o_osc_run |=> !o_freg_wr.we;
  endproperty
  property p_wback;
    go && regop && i_instr.dest |=>
      o_freg_wr.we && o_freg_wr.addr == $past(i_instr.addr);
  endproperty
  property p_acc_dest;
    go && regop && !i_instr.dest |=> !o_freg_wr.we;
  endproperty
  property p_swap;
    go && i_instr.op == ASX_OP_SWAP && i_instr.dest |=>
      o_freg_wr.data == {$past(i_freg_rdata[3:0]), $past(i_freg_rdata[7:4])};
  endproperty
  property p_raddr;
    go && regop |-> o_freg_raddr == i_instr.addr;
  endproperty
  property p_dir_b;
    go && i_instr.op == ASX_OP_DIR_LOAD && i_instr.addr == 7'h06 |=>
      $stable(o_port_a_direction);
  endproperty
  property p_lit_nowr;
    go && litop |=> !o_freg_wr.we;
  endproperty
  a_wdt_pulse: assert property (p_wdt_pulse)
    else $error("watchdog clear is not one pulse after sleep");
  a_osc_stop: assert property (p_osc_stop)
    else $error("oscillator still runs after sleep");
  a_refuse: assert property (p_refuse)
    else $error("instruction executed while asleep");
  a_wback: assert property (p_wback)
    else $error("register write back missing or misaddressed");
  a_acc_dest: assert property (p_acc_dest)
    else $error("register written although accumulator chosen");
  a_swap: assert property (p_swap)
    else $error("nibble exchange data wrong");
  a_raddr: assert property (p_raddr)
    else $error("register read address differs from instruction");
  a_dir_b: assert property (p_dir_b)
    else $error("port a direction changed by port b load");
  a_lit_nowr: assert property (p_lit_nowr)
    else $error("literal form wrote a file register");
endmodule : asx_monitor

bind asx_core asx_monitor mon_u (.*);

// >>> tb/test_alu_subtract_xor_swap_sleep.sv
// testbench: directed checks of subtract, swap, xor, direction and sleep
module test_alu_subtract_xor_swap_sleep;
  timeunit 1ns;
  timeprecision 1ps;
  import asx_pkg::*;
  // ==========================================================================
  // signals
  logic        i_clk_sys, i_rst_n, i_instr_valid, i_wake;
  asx_instr_t  i_instr;
  logic [7:0]  i_freg_rdata, o_port_a_direction, o_port_b_direction;
  logic [6:0]  o_freg_raddr;
  asx_fwr_t    o_freg_wr;
  logic        o_wdt_clear, o_osc_run;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready;
  logic [2:0]  st;
  int          failures = 0;
  int          samples_checked = 0;
  asx_core dut_u (.*);
  asx_freg_model mdl_u (.i_clk_sys(i_clk_sys), .i_raddr(o_freg_raddr),
                        .i_wr(o_freg_wr), .o_rdata(i_freg_rdata));
  initial begin
    i_clk_sys = 1'b0;
    forever #2 i_clk_sys = ~i_clk_sys;
  end
  // ==========================================================================
  // shared tasks
  task automatic results;
    if (failures == 0 && samples_checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask : results
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    samples_checked++;
    if (g !== e) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic tmo;
    failures++;
    $display("wrong value at %0t: wait ran out", $time);
    results();
  endtask : tmo
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    logic aw, w, b;
    aw = 1'b1;
    w = 1'b1;
    b = 1'b1;
    // an edge between calls, so no handshake line is set twice in one step
    @(posedge i_clk_sys);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    for (int n = 0; n < 40 && b; n++) begin
      @(posedge i_clk_sys);
      if (aw && s_axi_awready) begin
        aw = 1'b0;
        s_axi_awvalid <= 1'b0;
      end
      if (w && s_axi_wready) begin
        w = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
      if (s_axi_bvalid) begin
        b = 1'b0;
        rsp = s_axi_bresp;
        s_axi_bready <= 1'b0;
      end
    end
    if (b) tmo();
  endtask : axw
  task automatic axr(input logic [7:0] a);
    logic ar, r;
    ar = 1'b1;
    r = 1'b1;
    @(posedge i_clk_sys);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    for (int n = 0; n < 40 && r; n++) begin
      @(posedge i_clk_sys);
      if (ar && s_axi_arready) begin
        ar = 1'b0;
        s_axi_arvalid <= 1'b0;
      end
      if (s_axi_rvalid) begin
        r = 1'b0;
        rd = s_axi_rdata;
        rsp = s_axi_rresp;
        s_axi_rready <= 1'b0;
      end
    end
    if (r) tmo();
  endtask : axr
  task automatic ex(input asx_op_t op, input logic [6:0] a, input logic d,
                    input logic [7:0] k);
    i_instr <= '{op, a, d, k};
    i_instr_valid <= 1'b1;
    @(posedge i_clk_sys);
    i_instr_valid <= 1'b0;
    @(posedge i_clk_sys);
  endtask : ex
  // e packs {zero, half carry, carry, result}
  function automatic logic [10:0] subx(input logic [7:0] f, w, input logic b);
    logic [8:0] r;
    logic [4:0] h;
    r = {1'b0, f} + {1'b0, ~w} + 9'(b);
    h = {1'b0, f[3:0]} + {1'b0, ~w[3:0]} + 5'(b);
    return {r[7:0] == 8'h00, h[4], r[8], r[7:0]};
  endfunction : subx
  task automatic run(input asx_op_t op, input logic [6:0] a, input logic d,
                     input logic [7:0] k, w, input logic [10:0] e);
    axw(ASX_OFS_ACC, {24'h00_0000, w});
    ex(op, a, d, k);
    // the register space takes the write one edge after the request
    axr(ASX_OFS_ACC);
    if (d) chk(32'(mdl_u.mem[a]), 32'(e[7:0]));
    chk(rd, {24'h00_0000, d ? w : e[7:0]});
    axr(ASX_OFS_STATUS);
    chk(32'(rd[2:0]), 32'(e[10:8]));
    st = e[10:8];
  endtask : run
  // ==========================================================================
  // scenarios
  task automatic t_arith;
    run(ASX_OP_LIT_SUB, 7'h00, 1'b0, 8'h10, 8'h05, subx(8'h10, 8'h05, 1'b1));
    run(ASX_OP_LIT_SUB, 7'h00, 1'b0, 8'h10, 8'h10, subx(8'h10, 8'h10, 1'b1));
    run(ASX_OP_LIT_SUB, 7'h00, 1'b0, 8'h29, 8'h38, subx(8'h29, 8'h38, 1'b1));
    run(ASX_OP_REG_SUB, 7'h7F, 1'b1, 8'h00, 8'h33,
        subx(mdl_u.mem[127], 8'h33, 1'b1));
    run(ASX_OP_REG_SUB, 7'h00, 1'b0, 8'h00, 8'hF0,
        subx(mdl_u.mem[0], 8'hF0, 1'b1));
    run(ASX_OP_REG_SUBB, 7'h05, 1'b0, 8'h00, 8'h11,
        subx(mdl_u.mem[5], 8'h11, st[0]));
    run(ASX_OP_LIT_SUB, 7'h00, 1'b0, 8'h10, 8'h05, subx(8'h10, 8'h05, 1'b1));
    run(ASX_OP_REG_SUBB, 7'h06, 1'b1, 8'h00, 8'h22,
        subx(mdl_u.mem[6], 8'h22, st[0]));
    mdl_u.mem[10] = 8'h00;
    run(ASX_OP_SWAP, 7'h0A, 1'b0, 8'h00, 8'h77, {st, 8'h00});
    run(ASX_OP_SWAP, 7'h21, 1'b1, 8'h00, 8'h77,
        {st, mdl_u.mem[33][3:0], mdl_u.mem[33][7:4]});
    run(ASX_OP_XOR_LIT, 7'h00, 1'b0, 8'h5A, 8'h5A, {1'b1, st[1:0], 8'h00});
    run(ASX_OP_XOR_LIT, 7'h00, 1'b0, 8'h0F, 8'h5A, {1'b0, st[1:0], 8'h55});
    run(ASX_OP_XOR_REG, 7'h40, 1'b1, 8'h00, 8'hFF, {(mdl_u.mem[64] == 8'hFF),
        st[1:0], ~mdl_u.mem[64]});
  endtask : t_arith
  task automatic t_dir;
    axw(ASX_OFS_ACC, 32'h0000_00A5);
    ex(ASX_OP_DIR_LOAD, 7'h05, 1'b0, 8'h00);
    chk(32'(o_port_a_direction), 32'h0000_00A5);
    axw(ASX_OFS_ACC, 32'h0000_003C);
    ex(ASX_OP_DIR_LOAD, 7'h06, 1'b0, 8'h00);
    chk(32'(o_port_b_direction), 32'h0000_003C);
    axw(ASX_OFS_ACC, 32'h0000_00C3);
    ex(ASX_OP_DIR_LOAD, 7'h07, 1'b0, 8'h00);
    ex(ASX_OP_DIR_LOAD, 7'h04, 1'b0, 8'h00);
    axr(ASX_OFS_DIR_C);
    chk(rd, 32'h0000_00C3);
    chk(32'(o_port_a_direction), 32'h0000_00A5);
  endtask : t_dir
  task automatic t_sleep;
    axw(ASX_OFS_ACC, 32'h0000_0012);
    i_instr <= '{ASX_OP_SLEEP, 7'h00, 1'b0, 8'h00};
    i_instr_valid <= 1'b1;
    @(posedge i_clk_sys);
    i_instr_valid <= 1'b0;
    #1 chk(32'(o_wdt_clear), 32'h0000_0001);
    @(posedge i_clk_sys);
    axr(ASX_OFS_STATUS);
    chk(32'(rd[5:3]), 32'h0000_0006);
    chk(32'(o_osc_run), 32'h0000_0000);
    ex(ASX_OP_XOR_LIT, 7'h00, 1'b0, 8'hFF);
    axr(ASX_OFS_ACC);
    chk(rd, 32'h0000_0012);
    i_wake <= 1'b1;
    for (int n = 0; n < 20 && !o_osc_run; n++) @(posedge i_clk_sys);
    if (!o_osc_run) tmo();
    i_wake <= 1'b0;
    ex(ASX_OP_XOR_LIT, 7'h00, 1'b0, 8'h12);
    axr(ASX_OFS_ACC);
    chk(rd, 32'h0000_0000);
    ex(ASX_OP_SLEEP, 7'h00, 1'b0, 8'h00);
    chk(32'(o_osc_run), 32'h0000_0000);
    axw(ASX_OFS_WAKE, 32'h0000_0001);
    chk(32'(o_osc_run), 32'h0000_0001);
  endtask : t_sleep
  task automatic t_bus;
    axr(ASX_OFS_STATUS);
    chk(rd, 32'h0000_0018);
    chk(32'(rsp), 32'(ASX_RESP_OKAY));
    chk(32'(o_port_b_direction), 32'(ASX_DIR_RST));
    axr(8'h1C);
    chk(32'(rsp), 32'(ASX_RESP_SLVERR));
    axw(8'h1C, 32'h0000_0000);
    chk(32'(rsp), 32'(ASX_RESP_SLVERR));
  endtask : t_bus
  // ==========================================================================
  // main sequence
  initial begin
    i_rst_n = 1'b0;
    i_instr_valid = 1'b0;
    i_wake = 1'b0;
    i_instr = '0;
    s_axi_awaddr = 8'h00;
    s_axi_araddr = 8'h00;
    s_axi_wdata = 32'h0000_0000;
    s_axi_wstrb = 4'hF;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 3'h0;
    {s_axi_arvalid, s_axi_rready} = 2'h0;
    repeat (16) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    @(posedge i_clk_sys);
    t_bus();
    t_arith();
    t_dir();
    t_sleep();
    results();
  end
endmodule : test_alu_subtract_xor_swap_sleep
